// ===== core/serial_port.sv
// Serial port with boot-mode capture, status pin and APB registers.
// Assumes APB master on pclk; pins arrive asynchronous and are synchronised.
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
module serial_port
  import serial_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic rxd,
  output logic txd,
  input logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input logic boot_mode_pin_low,
  input logic boot_mode_pin_high,
  input logic first_fetch,
  input logic intack_cycle,
  input logic download_req,
  output logic status_n,
  output logic program_mode,
  output logic download_enable,
  output logic fetch_from_zero,
  output logic [1:0] boot_source
);
  logic [1:0] rxd_s, sclk_s, bl_s, bh_s;
  port_mode_e mode;
  stat_fn_e stat_fn;
  logic seven, ninth, int_clk, irda, gpo;
  logic [15:0] div, div_cnt;
  logic tick, acc, wr, hit, rx_take, clocked;
  logic [1:0] boot_cnt;
  boot_e boot_mode;
  logic boot_done, boot_take;
  logic [11:0] tx_shift;
  logic [3:0] tx_left, tx_phase;
  logic tx_busy, tx_load, tx_adv, tx_bit, armed;
  logic sclk_d, ext_rise, ext_fall, int_edge, s_rise, s_fall;
  logic [7:0] sc_cnt;
  rx_state_e rx_state;
  logic [8:0] rx_sh, rx_data;
  logic [3:0] rx_cnt, rx_phase, nbits;
  logic rx_valid, ferr, async_done, sync_done;
  logic [8:0] rx_word;
  logic [31:0] rd_mux;

  function automatic logic [11:0] async_frame(input logic [7:0] d, input logic adr,
                                             input logic sev, input logic nin);
    logic a;
    a = adr | ~nin;
    if (sev)
      return {3'b111, a, d[6:0], 1'b0};
    return {2'b11, a, d, 1'b0};
  endfunction : async_frame

  // Only the second stage of each synchroniser feeds logic
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_s <= 2'b11;
      sclk_s <= 2'b11;
      bl_s <= 2'b00;
      bh_s <= 2'b00;
    end
    else
    begin
      rxd_s <= {rxd_s[0], rxd};
      sclk_s <= {sclk_s[0], sclk_in};
      bl_s <= {bl_s[0], boot_mode_pin_low};
      bh_s <= {bh_s[0], boot_mode_pin_high};
    end
  end

  // External reset low restarts every flop, including the boot capture
  assign boot_take = !boot_done && boot_cnt == BOOT_WAIT;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_cnt <= 2'b00;
      boot_done <= 1'b0;
      boot_mode <= BOOT_RUN_ZERO;
      program_mode <= 1'b0;
      fetch_from_zero <= 1'b0;
    end
    else if (boot_take)
    begin
      boot_done <= 1'b1;
      boot_mode <= boot_e'({bl_s[1], bh_s[1]});
      program_mode <= bl_s[1] && bh_s[1];
      fetch_from_zero <= !bl_s[1] && !bh_s[1];
    end
    else if (!boot_done)
      boot_cnt <= boot_cnt + 2'b01;
  end
  assign boot_source = boot_mode;

  // The download grant follows the cable-selected mode only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      download_enable <= 1'b0;
    else
      download_enable <= download_req && program_mode;
  end

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign hit = paddr inside {REG_CTRL, REG_DIV, REG_TXDATA, REG_RXDATA, REG_STATUS};
  assign pready = 1'b1;
  assign pslverr = acc && !hit;
  assign rx_take = acc && !pwrite && paddr == REG_RXDATA;
  assign clocked = mode == MODE_CLOCKED;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode <= MODE_ASYNC;
      seven <= 1'b0;
      ninth <= 1'b0;
      int_clk <= 1'b0;
      irda <= 1'b0;
      stat_fn <= STAT_FETCH;
      gpo <= 1'b1;
      div <= BOOT_DIV;
    end
    else if (boot_take)
    begin
      // Clocked boot waits on the host's clock; async boots at 2400 bps
      mode <= boot_mode_pin_code(bl_s[1], bh_s[1]);
      int_clk <= 1'b0;
      div <= BOOT_DIV;
    end
    else if (wr && paddr == REG_CTRL)
    begin
      mode <= port_mode_e'(pwdata[C_MODE +: 2]);
      seven <= pwdata[C_SEVEN];
      ninth <= pwdata[C_NINTH];
      int_clk <= pwdata[C_INTCLK];
      irda <= pwdata[C_IRDA];
      stat_fn <= stat_fn_e'(pwdata[C_STFN +: 2]);
      gpo <= pwdata[C_GPO];
    end
    else if (wr && paddr == REG_DIV)
      div <= pwdata[15:0];
  end

  function automatic port_mode_e boot_mode_pin_code(input logic lo, input logic hi);
    return (lo && !hi) ? MODE_CLOCKED : MODE_ASYNC;
  endfunction : boot_mode_pin_code

  // One tick per div+1 clocks; sixteen ticks make an async bit
  assign tick = div_cnt == 16'h0000;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt <= 16'h0000;
    else if (tick || tx_load)
      div_cnt <= div;
    else
      div_cnt <= div_cnt - 16'h0001;
  end

  // Own clock: half period is SYNC_HALF ticks, so period >= 160 clocks
  assign int_edge = clocked && int_clk && tx_busy && tick && sc_cnt == SYNC_HALF - 8'h01;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sc_cnt <= 8'h00;
      sclk_out <= 1'b1;
      sclk_oe <= 1'b0;
      sclk_d <= 1'b1;
    end
    else
    begin
      sclk_d <= sclk_s[1];
      sclk_oe <= clocked && int_clk;
      if (!(clocked && int_clk && tx_busy))
      begin
        sc_cnt <= 8'h00;
        sclk_out <= 1'b1;
      end
      else if (int_edge)
      begin
        sc_cnt <= 8'h00;
        sclk_out <= ~sclk_out;
      end
      else if (tick)
        sc_cnt <= sc_cnt + 8'h01;
    end
  end
  assign ext_rise = clocked && !int_clk && sclk_s[1] && !sclk_d;
  assign ext_fall = clocked && !int_clk && !sclk_s[1] && sclk_d;
  assign s_rise = ext_rise || (int_edge && !sclk_out);
  assign s_fall = ext_fall || (int_edge && sclk_out);

  // Writes to TXDATA while busy are dropped; poll the busy bit first
  assign tx_load = wr && paddr == REG_TXDATA && !tx_busy;
  assign tx_adv = clocked ? (s_fall && armed) : (tick && tx_phase == PH_LAST);
  assign tx_bit = tx_busy ? tx_shift[0] : 1'b1;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_shift <= 12'hFFF;
      tx_left <= 4'h0;
      tx_phase <= 4'h0;
      tx_busy <= 1'b0;
      armed <= 1'b0;
    end
    else if (tx_load)
    begin
      tx_busy <= 1'b1;
      tx_phase <= 4'h0;
      armed <= 1'b0;
      if (mode == MODE_ASYNC)
      begin
        tx_shift <= async_frame(pwdata[7:0], pwdata[T_ADR], seven, ninth);
        tx_left <= (seven ? 4'h9 : 4'hA) + {3'b000, ninth};
      end
      else
      begin
        tx_shift <= {4'hF, pwdata[T_FLAG] ? HDLC_FLAG : pwdata[7:0]};
        tx_left <= 4'h8;
      end
    end
    else if (tx_busy)
    begin
      if (!clocked && tick)
        tx_phase <= tx_phase + 4'h1;
      if (tx_adv)
        tx_shift <= {1'b1, tx_shift[11:1]};
      if (clocked ? s_rise : tx_adv)
      begin
        armed <= 1'b1;
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1)
          tx_busy <= 1'b0;
      end
    end
  end

  // Infrared in HDLC mode only: a zero is a short low pulse at the start of the bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      txd <= 1'b1;
    else if (irda && mode == MODE_HDLC && !tx_bit)
      txd <= tx_phase >= IRDA_PULSE;
    else
      txd <= tx_bit;
  end

  assign nbits = (seven ? 4'h7 : 4'h8) + {3'b000, ninth};
  assign async_done = rx_state == RX_STOP && tick && rx_phase == PH_LAST;
  assign sync_done = clocked && s_rise && rx_cnt == 4'h7;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_state <= RX_IDLE;
      rx_sh <= 9'h000;
      rx_cnt <= 4'h0;
      rx_phase <= 4'h0;
    end
    else if (clocked)
    begin
      rx_state <= RX_IDLE;
      if (s_rise)
      begin
        rx_sh <= {rxd_s[1], rx_sh[8:1]};
        rx_cnt <= sync_done ? 4'h0 : rx_cnt + 4'h1;
      end
    end
    else
    begin
      case (rx_state)
        RX_IDLE:
        begin
          rx_phase <= 4'h0;
          rx_cnt <= 4'h0;
          if (mode == MODE_ASYNC && !rxd_s[1])
            rx_state <= RX_START;
        end
        RX_START:
          if (tick)
          begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == PH_MID)
            begin
              rx_phase <= 4'h0;
              rx_state <= rxd_s[1] ? RX_IDLE : RX_BITS;
            end
          end
        RX_BITS:
          if (tick)
          begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == PH_LAST)
            begin
              rx_sh <= {rxd_s[1], rx_sh[8:1]};
              rx_cnt <= rx_cnt + 4'h1;
              if (rx_cnt == nbits - 4'h1)
                rx_state <= RX_STOP;
            end
          end
        RX_STOP:
          if (tick)
          begin
            rx_phase <= rx_phase + 4'h1;
            if (rx_phase == PH_LAST)
              rx_state <= RX_IDLE;
          end
        default:
          rx_state <= RX_IDLE;
      endcase
    end
  end

  // Received word normalised to {address flag, data}
  always_comb
  begin
    logic [8:0] al;
    al = rx_sh >> (4'h9 - nbits);
    if (seven)
      rx_word = {ninth & al[7], 1'b0, al[6:0]};
    else
      rx_word = {ninth & al[8], al[7:0]};
  end

  // A new byte in the same cycle as a read still leaves valid set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_data <= 9'h000;
      rx_valid <= 1'b0;
      ferr <= 1'b0;
    end
    else
    begin
      if (sync_done)
        rx_data <= {1'b0, rxd_s[1], rx_sh[8:2]};
      else if (async_done && rxd_s[1])
        rx_data <= rx_word;
      if (sync_done || (async_done && rxd_s[1]))
        rx_valid <= 1'b1;
      else if (rx_take)
        rx_valid <= 1'b0;
      if (async_done && !rxd_s[1])
        ferr <= 1'b1;
      else if (wr && paddr == REG_STATUS && pwdata[S_FERR])
        ferr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_n <= 1'b1;
    else
      case (stat_fn)
        STAT_FETCH: status_n <= !first_fetch;
        STAT_INTACK: status_n <= !intack_cycle;
        STAT_GPO: status_n <= gpo;
        default: status_n <= 1'b1;
      endcase
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      REG_CTRL: rd_mux[8:0] = {gpo, stat_fn, irda, int_clk, ninth, seven, mode};
      REG_DIV: rd_mux[15:0] = div;
      REG_RXDATA: rd_mux[8:0] = rx_data;
      REG_STATUS:
      begin
        rd_mux[S_BUSY] = tx_busy;
        rd_mux[S_RXV] = rx_valid;
        rd_mux[S_ADR] = rx_data[8];
        rd_mux[S_FERR] = ferr;
        rd_mux[S_GPI] = sclk_s[1];
        rd_mux[S_BOOT +: 2] = boot_mode;
        rd_mux[S_PROGRAM_CABLE_CONNECTOR] = program_mode;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup phase so the access needs no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  logic [7:0] hold_cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_cnt <= 8'h00;
    else if (int_edge)
      hold_cnt <= 8'h00;
    else if (hold_cnt != 8'hFF)
      hold_cnt <= hold_cnt + 8'h01;
  end

  // Ticks per transmitted bit, counted apart from the phase counter it checks
  logic [4:0] bit_ticks;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bit_ticks <= 5'h00;
    else if (tx_load || tx_adv)
      bit_ticks <= 5'h00;
    else if (tick && tx_busy)
      bit_ticks <= bit_ticks + 5'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_boot_wait;
    !boot_done ##1 boot_take;
  endsequence
  sequence s_boot_hold;
    boot_done [*3];
  endsequence

  chk_async_bit_time: assert property (
    (tx_busy && mode == MODE_ASYNC && tx_adv) |-> tick && bit_ticks == 5'(OVERSAMPLE - 1))
    else $error("async bit ended off the sixteenth tick");
  chk_frame_length: assert property (
    (tx_load && mode == MODE_ASYNC)
    |=> tx_left == $past(nbits) + 4'h2)
    else $error("async frame length wrong");
  chk_ninth_mark: assert property (
    (tx_load && mode == MODE_ASYNC && ninth && !seven) |=> tx_shift[9] == $past(pwdata[T_ADR]))
    else $error("ninth bit not taken from address flag");
  chk_clock_drive: assert property (
    sclk_oe |-> $past(clocked && int_clk))
    else $error("clock driven outside own-clock mode");
  chk_sync_rate: assert property (
    (int_edge && hold_cnt != 8'hFF) |-> hold_cnt >= SYNC_HALF - 8'h01)
    else $error("own clock half period too short");
  chk_irda_pulse: assert property (
    (irda && mode == MODE_HDLC && !txd && $past(irda && mode == MODE_HDLC))
    |-> $past(tx_phase) < IRDA_PULSE)
    else $error("infrared pulse shape wrong");
  chk_gpi_free: assert property (
    (mode == MODE_ASYNC) |=> !sclk_oe)
    else $error("clock line driven in async mode");
  chk_boot_latch: assert property (
    s_boot_wait |=> s_boot_hold ##0 (fetch_from_zero == (boot_mode == BOOT_RUN_ZERO)))
    else $error("boot decision not held");
  chk_boot_rate: assert property (
    (boot_take && bl_s[1] && bh_s[1]) |=> div == BOOT_DIV && mode == MODE_ASYNC)
    else $error("async boot not at 2400 bps");
  chk_status_fetch: assert property (
    (stat_fn == STAT_FETCH && first_fetch) |=> !status_n)
    else $error("status not low on first fetch");
  chk_download_gate: assert property (
    download_enable |-> program_mode && $past(download_req))
    else $error("download granted outside program mode");
  chk_start_check: assert property (
    (rx_state == RX_START && tick && rx_phase == PH_MID && rxd_s[1]) |=> rx_state == RX_IDLE)
    else $error("false start bit accepted");
endmodule : serial_port

// ===== core/serial_pkg.sv
// Serial port package: register map, field positions, modes and timing.
// Assumes one 20 MHz APB clock and pins synchronised inside the port.
package serial_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned OVERSAMPLE = 16;
  localparam int unsigned BOOT_BAUD = 2400;
  localparam logic [15:0] BOOT_DIV = 16'(CLK_HZ / (OVERSAMPLE * BOOT_BAUD) - 1);
  localparam int unsigned SYNC_DIV = 128;
  localparam int unsigned SYNC_PCT = 80;
  localparam logic [7:0] SYNC_HALF = 8'((SYNC_DIV * 100 / SYNC_PCT + 1) / 2);
  localparam logic [3:0] PH_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] PH_MID = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] IRDA_PULSE = 4'h3;
  localparam logic [7:0] HDLC_FLAG = 8'h7E;
  localparam logic [1:0] BOOT_WAIT = 2'h2;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DIV = 8'h04;
  localparam logic [7:0] REG_TXDATA = 8'h08;
  localparam logic [7:0] REG_RXDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  localparam int C_MODE = 0;
  localparam int C_SEVEN = 2;
  localparam int C_NINTH = 3;
  localparam int C_INTCLK = 4;
  localparam int C_IRDA = 5;
  localparam int C_STFN = 6;
  localparam int C_GPO = 8;
  localparam int T_ADR = 8;
  localparam int T_FLAG = 9;
  localparam int S_BUSY = 0;
  localparam int S_RXV = 1;
  localparam int S_ADR = 2;
  localparam int S_FERR = 3;
  localparam int S_GPI = 4;
  localparam int S_BOOT = 5;
  localparam int S_PROGRAM_CABLE_CONNECTOR = 7;

  typedef enum logic [1:0] {
    MODE_ASYNC = 2'b00,
    MODE_CLOCKED = 2'b01,
    MODE_HDLC = 2'b10
  } port_mode_e;

  typedef enum logic [1:0] {
    STAT_FETCH = 2'b00,
    STAT_INTACK = 2'b01,
    STAT_GPO = 2'b10
  } stat_fn_e;

  typedef enum logic [1:0] {
    BOOT_RUN_ZERO = 2'b00,
    BOOT_SLAVE = 2'b01,
    BOOT_CLOCKED = 2'b10,
    BOOT_ASYNC = 2'b11
  } boot_e;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_STOP = 2'b11
  } rx_state_e;
endpackage : serial_pkg

// ===== testbench/serial_peer.sv
// Serial peer on the far side of the port: sends async frames, decodes
// async and own-clock frames from the port. The bench sets nbits, async_on and rv.
`timescale 1ns/1ns
module serial_peer (
  input wire logic pclk,
  input wire logic txd,
  input wire logic sclk_out,
  input wire logic sclk_oe,
  output logic rxd,
  output logic sclk_in
);
  int nbits = 8;
  bit async_on = 1'b1;
  int low_n = 0;
  int last_low = 0;
  int sn = 0;
  logic [8:0] got_q[$];
  logic [7:0] sv;
  int rn = 0;
  logic [7:0] rv = 8'hFF;

  initial
  begin
    rxd = 1'b1;
    sclk_in = 1'b1;
  end

  // Mid-bit sampling leaves half a bit of slack for the one-tick start jitter
  always
  begin : async_rx
    logic [8:0] v;
    @(negedge txd);
    if (async_on)
    begin
      v = '0;
      repeat (8) @(posedge pclk);
      for (int i = 0; i < nbits; i++)
      begin
        repeat (16) @(posedge pclk);
        v[i] = txd;
      end
      repeat (16) @(posedge pclk);
      got_q.push_back(v);
    end
  end

  always @(posedge sclk_out)
  begin
    if (sclk_oe === 1'b1)
    begin
      sv = {txd, sv[7:1]};
      sn++;
      if (sn == 8)
      begin
        got_q.push_back({1'b0, sv});
        sn = 0;
      end
    end
  end

  // Own-clock receive: next bit goes out on each falling edge, LSB first
  always @(negedge sclk_out)
  begin
    if (sclk_oe === 1'b1)
    begin
      rxd <= rv[rn];
      rn = (rn + 1) % 8;
    end
  end

  always @(posedge pclk)
  begin
    if (sclk_oe === 1'b1 && sclk_out === 1'b0)
      low_n <= low_n + 1;
    else if (low_n != 0)
    begin
      last_low <= low_n;
      low_n <= 0;
    end
  end

  task automatic send(input logic [8:0] v, input int n, input logic stop);
    rxd <= 1'b0;
    repeat (16) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= v[i];
      repeat (16) @(posedge pclk);
    end
    rxd <= stop;
    repeat (16) @(posedge pclk);
    rxd <= 1'b1;
  endtask : send
endmodule : serial_peer

// ===== testbench/serial_port_tb.sv
// Self-checking bench for the serial port: APB master, boot pins, peer.
// Assumes nothing about APB wait states; every access waits on pready.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin err_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, gt); end end
module serial_port_tb;
  import serial_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rxd, txd, sclk_in, sclk_out, sclk_oe, status_n, program_mode;
  logic boot_mode_pin_low, boot_mode_pin_high, first_fetch, intack_cycle, download_req;
  logic download_enable, fetch_from_zero;
  logic [1:0] boot_source, p;
  logic [8:0] d, g, mask;
  int err_count = 0;
  int compares = 0;
  int lows = 0;
  logic [7:0] rv_exp;
  integer seed = 32'h2A82AB13;

  serial_port u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxd, .txd, .sclk_in, .sclk_out, .sclk_oe, .boot_mode_pin_low,
    .boot_mode_pin_high, .first_fetch, .intack_cycle, .download_req, .status_n,
    .program_mode, .download_enable, .fetch_from_zero, .boot_source);
  serial_peer u_peer (.pclk, .txd, .sclk_out, .sclk_oe, .rxd, .sclk_in);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, REG_STATUS, '0, rd);
      n++;
    end
    while (rd[b] !== v && n < 2000);
    if (rd[b] !== v)
    begin
      err_count++;
      $display("CHECK FAILED status bit %0d expected %0h seen %0h", b, v, rd[b]);
    end
  endtask : poll

  task automatic do_reset(input logic [1:0] pat);
    presetn <= 1'b0;
    boot_mode_pin_low <= pat[1];
    boot_mode_pin_high <= pat[0];
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
  endtask : do_reset

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (30000) @(posedge pclk);
    err_count++;
    wrap_up();
  end

  initial
  begin
    {psel, penable, pwrite, first_fetch, intack_cycle, download_req} = '0;
    paddr = '0;
    pwdata = '0;
    for (int k = 0; k < 4; k++)
    begin
      p = k[1:0];
      do_reset(p);
      `CHK("boot_source", p, boot_source)
      `CHK("program_mode", (p == 2'b11), program_mode)
      `CHK("fetch_from_zero", (p == 2'b00), fetch_from_zero)
      apb(1'b0, REG_STATUS, '0, rd);
      `CHK("status boot", {p == 2'b11, p}, rd[7:5])
      download_req <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("download_enable", (p == 2'b11), download_enable)
      download_req <= 1'b0;
      @(posedge pclk);
    end
    apb(1'b0, REG_CTRL, '0, rd);
    `CHK("ctrl reset", 32'h00000100, rd)
    apb(1'b0, REG_DIV, '0, rd);
    `CHK("div reset", 32'(CLK_HZ / (16 * 2400) - 1), rd)
    apb(1'b0, 8'h14, '0, rd);
    `CHK("unmapped read", 32'h00000000, rd)
    `CHK("unmapped error", 1'b1, slv)
    // Fastest divider gives sixteen clocks per bit, the top async rate
    apb(1'b1, REG_DIV, 32'h00000000, rd);
    for (int k = 0; k < 3; k++)
    begin
      u_peer.nbits = 8 - (k == 1) + (k == 2);
      mask = (k == 1) ? 9'h07F : ((k == 2) ? 9'h1FF : 9'h0FF);
      apb(1'b1, REG_CTRL, (k == 1) ? 32'h104 : ((k == 2) ? 32'h108 : 32'h100), rd);
      d = 9'($random(seed)) & mask;
      apb(1'b1, REG_TXDATA, {23'h0, d}, rd);
      poll(S_BUSY, 1'b0);
      repeat (20) @(posedge pclk);
      g = u_peer.got_q.size() ? u_peer.got_q.pop_front() : 'x;
      `CHK("tx frame", d, g)
      d = 9'($random(seed)) & mask;
      u_peer.send(d, u_peer.nbits, 1'b1);
      poll(S_RXV, 1'b1);
      apb(1'b0, REG_RXDATA, '0, rd);
      `CHK("rx frame", d, rd[8:0])
    end
    u_peer.send(9'h055, u_peer.nbits, 1'b0);
    poll(S_FERR, 1'b1);
    `CHK("bad stop no data", 1'b0, rd[S_RXV])
    apb(1'b1, REG_STATUS, 32'h00000008, rd);
    apb(1'b0, REG_STATUS, '0, rd);
    `CHK("frame error clear", 1'b0, rd[S_FERR])
    for (int k = 0; k < 2; k++)
    begin
      u_peer.sclk_in <= k[0];
      repeat (4) @(posedge pclk);
      apb(1'b0, REG_STATUS, '0, rd);
      `CHK("clock pin input", k[0], rd[S_GPI])
    end
    for (int f = 0; f < 3; f++)
    begin
      apb(1'b1, REG_CTRL, 32'h100 | (f << 6), rd);
      first_fetch <= (f == 1);
      intack_cycle <= (f == 0);
      repeat (3) @(posedge pclk);
      `CHK("status idle", 1'b1, status_n)
      first_fetch <= (f == 0);
      intack_cycle <= (f == 1);
      if (f == 2)
        apb(1'b1, REG_CTRL, 32'h080, rd);
      repeat (3) @(posedge pclk);
      `CHK("status low", 1'b0, status_n)
      first_fetch <= 1'b0;
      intack_cycle <= 1'b0;
    end
    u_peer.async_on = 1'b0;
    rv_exp = 8'($random(seed));
    u_peer.rv = rv_exp;
    apb(1'b1, REG_CTRL, 32'h111, rd);
    d = 9'($random(seed)) & 9'h0FF;
    apb(1'b1, REG_TXDATA, {23'h0, d}, rd);
    poll(S_BUSY, 1'b0);
    repeat (4) @(posedge pclk);
    g = u_peer.got_q.size() ? u_peer.got_q.pop_front() : 'x;
    `CHK("clocked frame", d, g)
    `CHK("own clock period", 1'b1, (u_peer.last_low * 2 >= 128 * 100 / 80))
    apb(1'b0, REG_RXDATA, '0, rd);
    `CHK("clocked rx", {1'b0, rv_exp}, rd[8:0])
    // Infrared HDLC: every zero bit is a low pulse of three ticks, one tick per clock
    apb(1'b1, REG_CTRL, 32'h122, rd);
    for (int j = 0; j < 2; j++)
    begin
      d = 9'($random(seed)) & 9'h0EF;
      apb(1'b1, REG_TXDATA, {22'h0, j[0], d}, rd);
      lows = 0;
      repeat (150)
      begin
        @(negedge pclk);
        lows += (txd === 1'b0);
      end
      @(posedge pclk);
      rv_exp = j[0] ? HDLC_FLAG : d[7:0];
      `CHK("infrared lows", 3 * (8 - $countones(rv_exp)), lows)
    end
    wrap_up();
  end
endmodule : serial_port_tb
